// ### g1hc_group1_handshake_config.sv
`timescale 1ns/1ps
`include "g1hc_regs.svh"
module g1hc_group1_handshake_config (
  input wire logic sys_clk, // board clock, 125 MHz
  input wire logic rst, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error on unmapped address
  input wire logic grp1RequestIn, // request pin, asynchronous
  input wire logic grp1DataTaken, // pulse: port logic consumed data
  output logic grp1DmaRequest, // dma request level
  output logic grp1IrqRequest, // handshake interrupt request level
  output logic irq, // masked sticky status interrupt
  output logic portAHandshakeEnable, // port a in handshaking
  output logic portBHandshakeEnable, // port b in handshaking
  output logic grp1DataReadyFlag, // data ready level
  output logic grp1SettleBusy // settle delay running
);

  g1hc_pkg::g1hc_state_s q;
  g1hc_pkg::g1hc_state_s d;
  g1hc_settle_if st ();

  logic reqActive;
  logic hsEnable;
  logic localRst;
  logic setupRd;
  logic accWr;
  logic accRd;
  logic mapped;
  logic evReq;
  logic evReady;
  logic [2:0] delaySel;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  g1hc_settle_timer u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .tmr(st.timer)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.syncA = grp1RequestIn;
    d.syncB = q.syncA;
    reqActive = q.syncB ^ q.cfg[`G1HC_INV_BIT];
    hsEnable = q.cfg[`G1HC_PA_EN_BIT] | q.cfg[`G1HC_PB_EN_BIT];
    localRst = q.cfg[`G1HC_LRST_BIT];
    delaySel = q.cfg[`G1HC_DLY_HI:`G1HC_DLY_LO];
    st.start = 1'b0;
    st.count = g1hc_pkg::settle_cycles(delaySel);
    evReq = 1'b0;
    evReady = 1'b0;
    setupRd = psel && !penable;
    accWr = psel && penable && pwrite;
    accRd = psel && penable && !pwrite;
    mapped = 1'b0;
    if (hit(paddr, `G1HC_CFG_OFF)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `G1HC_STAT_OFF)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `G1HC_MASK_OFF)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `G1HC_STATE_OFF)) begin
      mapped = 1'b1;
    end
    // register writes
    if (accWr && hit(paddr, `G1HC_CFG_OFF)) begin
      d.cfg = pwdata[15:0];
      d.cfg[`G1HC_IGN_BIT] = 1'b0;
    end else if (accWr && hit(paddr, `G1HC_MASK_OFF)) begin
      d.mask = pwdata[1:0];
    end
    // read data is captured in the setup cycle
    if (setupRd) begin
      if (hit(paddr, `G1HC_STAT_OFF)) begin
        d.rdata = {30'h0, q.stat};
      end else if (hit(paddr, `G1HC_MASK_OFF)) begin
        d.rdata = {30'h0, q.mask};
      end else if (hit(paddr, `G1HC_STATE_OFF)) begin
        d.rdata = {26'h0, q.fsm, q.drdy, reqActive};
      end else begin
        d.rdata = 32'h0;
      end
    end
    // handshake sequence
    if (localRst) begin
      d.fsm = g1hc_pkg::HS_IDLE;
      d.drdy = 1'b0;
    end else begin
      case (q.fsm)
        g1hc_pkg::HS_IDLE: begin
          if (reqActive && hsEnable) begin
            st.start = 1'b1;
            evReq = 1'b1;
            d.fsm = g1hc_pkg::HS_SETTLE;
          end
        end
        g1hc_pkg::HS_SETTLE: begin
          if (st.idle) begin
            evReady = 1'b1;
            d.drdy = 1'b1;
            d.fsm = g1hc_pkg::HS_READY;
          end
        end
        g1hc_pkg::HS_READY: begin
          if (grp1DataTaken) begin
            d.drdy = 1'b0;
            d.fsm = g1hc_pkg::HS_RELEASE;
          end
        end
        g1hc_pkg::HS_RELEASE: begin
          if (!reqActive) begin
            d.fsm = g1hc_pkg::HS_IDLE;
          end
        end
        default: begin
          d.fsm = g1hc_pkg::HS_IDLE;
        end
      endcase
    end
    // sticky status: read clears, a new event wins
    if (accRd && hit(paddr, `G1HC_STAT_OFF)) begin
      d.stat = 2'h0;
    end
    if (evReq) begin
      d.stat[`G1HC_ST_REQ_BIT] = 1'b1;
    end
    if (evReady) begin
      d.stat[`G1HC_ST_RDY_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.cfg <= `G1HC_CFG_RST;
      q.mask <= `G1HC_MASK_RST;
      q.fsm <= g1hc_pkg::HS_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = psel && penable && !mapped;
  assign grp1DmaRequest = q.cfg[`G1HC_DMA_EN_BIT] && q.drdy;
  assign grp1IrqRequest = q.cfg[`G1HC_IRQ_EN_BIT] && q.drdy;
  assign irq = |(q.stat & q.mask);
  assign portAHandshakeEnable = q.cfg[`G1HC_PA_EN_BIT];
  assign portBHandshakeEnable = q.cfg[`G1HC_PB_EN_BIT];
  assign grp1DataReadyFlag = q.drdy;
  assign grp1SettleBusy = (q.fsm == g1hc_pkg::HS_SETTLE);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [7:0] hlpCnt;
  logic [2:0] hlpSel;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hlpCnt <= 8'h00;
      hlpSel <= 3'h0;
    end else if (st.start) begin
      hlpCnt <= 8'h00;
      hlpSel <= delaySel;
    end else if (q.fsm == g1hc_pkg::HS_SETTLE) begin
      hlpCnt <= hlpCnt + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence cfgWrite;
    psel && penable && pwrite && (paddr == `G1HC_CFG_OFF);
  endsequence

  sequence settleExit;
    (q.fsm == g1hc_pkg::HS_SETTLE) && !localRst ##1 (q.fsm == g1hc_pkg::HS_READY);
  endsequence

  sequence idleArmed;
    (q.fsm == g1hc_pkg::HS_IDLE) && hsEnable && !localRst;
  endsequence

  cfg_write_decode_a: assert property (
    cfgWrite |=> (q.cfg[15:8] == $past(pwdata[15:8])) && (q.cfg[6:0] == $past(pwdata[6:0])))
    else $error("config word not taken from a write at offset zero");

  dma_req_level_a: assert property (
    grp1DmaRequest == (q.cfg[`G1HC_DMA_EN_BIT] && (q.fsm == g1hc_pkg::HS_READY)))
    else $error("dma request does not follow enable while data ready");

  irq_req_level_a: assert property (
    ((q.fsm != g1hc_pkg::HS_READY) |-> !grp1IrqRequest)
      and (q.drdy && q.cfg[`G1HC_IRQ_EN_BIT] |-> grp1IrqRequest))
    else $error("interrupt request does not follow data ready");

  settle_length_a: assert property (
    settleExit |-> (hlpCnt == 8'(g1hc_pkg::settle_cycles(hlpSel)) + 8'h01))
    else $error("settle phase length differs from selected delay");

  settle_min_time_a: assert property (
    settleExit |-> (32'(hlpCnt) * 32'(`G1HC_CLK_PERIOD_NS)
      >= 32'(hlpSel) * 32'(`G1HC_SETTLE_STEP_NS)))
    else $error("settle phase shorter than selected nanoseconds");

  port_enable_out_a: assert property (
    cfgWrite |=> (portBHandshakeEnable == $past(pwdata[10]))
      && (portAHandshakeEnable == $past(pwdata[9])))
    else $error("port handshake enables do not follow written bits");

  local_reset_a: assert property (
    localRst |=> (q.fsm == g1hc_pkg::HS_IDLE) && !q.drdy && !grp1DmaRequest)
    else $error("local reset does not return handshake to idle");

  bit7_ignored_a: assert property (
    cfgWrite |=> !q.cfg[`G1HC_IGN_BIT])
    else $error("ignored bit changed stored state");

  req_active_low_a: assert property (
    idleArmed and q.cfg[`G1HC_INV_BIT] |->
      if (q.syncB) ##1 (q.fsm == g1hc_pkg::HS_IDLE) else ##1 (q.fsm == g1hc_pkg::HS_SETTLE))
    else $error("inverted request not recognised while low");

  req_active_high_a: assert property (
    idleArmed and !q.cfg[`G1HC_INV_BIT] |->
      if (q.syncB) ##1 (q.fsm == g1hc_pkg::HS_SETTLE) else ##1 (q.fsm == g1hc_pkg::HS_IDLE))
    else $error("request not recognised while high");

  reset_clear_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    rst |-> (q.cfg == 16'h0000) && !portAHandshakeEnable && !grp1DmaRequest)
    else $error("config word not cleared by reset");

  // ----------------------------------------
  // bus, status and sequencing checks
  // ----------------------------------------
  sequence setupRead;
    psel && !penable && !pwrite;
  endsequence

  sequence statRead;
    psel && penable && !pwrite && (paddr == `G1HC_STAT_OFF);
  endsequence

  sequence maskWrite;
    psel && penable && pwrite && (paddr == `G1HC_MASK_OFF);
  endsequence

  sequence takenInReady;
    (q.fsm == g1hc_pkg::HS_READY) && grp1DataTaken && !localRst;
  endsequence

  slverr_unmapped_a: assert property (
    psel && penable |-> pslverr == !((paddr == `G1HC_CFG_OFF) || (paddr == `G1HC_STAT_OFF)
      || (paddr == `G1HC_MASK_OFF) || (paddr == `G1HC_STATE_OFF)))
    else $error("error response does not match the address map");

  slverr_idle_a: assert property (
    !(psel && penable) |-> !pslverr)
    else $error("error response outside an access phase");

  cfg_read_zero_a: assert property (
    setupRead ##0 (paddr == `G1HC_CFG_OFF) |=> (prdata == 32'h0))
    else $error("write-only config word returned data");

  stat_read_data_a: assert property (
    setupRead ##0 (paddr == `G1HC_STAT_OFF) |=> (prdata == {30'h0, $past(q.stat)}))
    else $error("status read data does not match status bits");

  mask_read_data_a: assert property (
    setupRead ##0 (paddr == `G1HC_MASK_OFF) |=> (prdata == {30'h0, $past(q.mask)}))
    else $error("mask read data does not match mask bits");

  state_read_data_a: assert property (
    setupRead ##0 (paddr == `G1HC_STATE_OFF) |=> (prdata[5:2] == $past(q.fsm)))
    else $error("state read data does not match handshake state");

  mask_write_a: assert property (
    maskWrite |=> (q.mask == $past(pwdata[1:0])))
    else $error("mask not taken from a write");

  stat_read_clear_a: assert property (
    statRead ##0 (!evReq && !evReady) |=> (q.stat == 2'h0))
    else $error("status not cleared by its read");

  ready_stat_set_a: assert property (
    evReady |=> q.stat[`G1HC_ST_RDY_BIT])
    else $error("data ready event lost from status");

  req_stat_set_a: assert property (
    evReq |=> q.stat[`G1HC_ST_REQ_BIT])
    else $error("request event lost from status");

  taken_release_a: assert property (
    takenInReady |=> (q.fsm == g1hc_pkg::HS_RELEASE) && !grp1DataReadyFlag)
    else $error("data taken does not end data ready");

  release_hold_a: assert property (
    (q.fsm == g1hc_pkg::HS_RELEASE) && reqActive && !localRst
      |=> (q.fsm == g1hc_pkg::HS_RELEASE))
    else $error("release left while request still active");

  busy_start_a: assert property (
    st.start |=> grp1SettleBusy)
    else $error("settle phase not entered on start");

  ready_from_settle_a: assert property (
    $rose(grp1DataReadyFlag) |-> ($past(q.fsm) == g1hc_pkg::HS_SETTLE))
    else $error("data ready raised outside the settle phase");

  sync_depth_a: assert property (
    q.syncB == $past(grp1RequestIn, 2))
    else $error("request pin not seen through two flops");

  fsm_onehot_a: assert property (
    $onehot(q.fsm))
    else $error("handshake state not one-hot");

  disabled_idle_a: assert property (
    (q.fsm == g1hc_pkg::HS_IDLE) && !hsEnable |=> (q.fsm == g1hc_pkg::HS_IDLE))
    else $error("request accepted with no port enabled");

endmodule : g1hc_group1_handshake_config

// ### g1hc_regs.svh
`ifndef G1HC_REGS_SVH
`define G1HC_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define G1HC_CFG_OFF 8'h00
`define G1HC_STAT_OFF 8'h04
`define G1HC_MASK_OFF 8'h08
`define G1HC_STATE_OFF 8'h0c

// ----------------------------------------
// configuration field positions
// ----------------------------------------
`define G1HC_DMA_EN_BIT 15
`define G1HC_IRQ_EN_BIT 14
`define G1HC_DLY_HI 13
`define G1HC_DLY_LO 11
`define G1HC_PB_EN_BIT 10
`define G1HC_PA_EN_BIT 9
`define G1HC_LRST_BIT 8
`define G1HC_IGN_BIT 7
`define G1HC_INV_BIT 6

// ----------------------------------------
// status bits and reset values
// ----------------------------------------
`define G1HC_ST_REQ_BIT 0
`define G1HC_ST_RDY_BIT 1
`define G1HC_CFG_RST 16'h0000
`define G1HC_MASK_RST 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define G1HC_CLK_PERIOD_NS 8
`define G1HC_SETTLE_STEP_NS 100
`define G1HC_STEP_CYC ((`G1HC_SETTLE_STEP_NS + `G1HC_CLK_PERIOD_NS - 1) / `G1HC_CLK_PERIOD_NS)

`endif

// ### g1hc_pkg.sv
`include "g1hc_regs.svh"
package g1hc_pkg;

  typedef logic [6:0] g1hc_count_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_SETTLE = 4'b0010,
    HS_READY = 4'b0100,
    HS_RELEASE = 4'b1000
  } g1hc_hs_e;

  typedef struct packed {
    logic [15:0] cfg;
    logic syncA;
    logic syncB;
    g1hc_hs_e fsm;
    logic drdy;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] rdata;
  } g1hc_state_s;

  typedef struct packed {
    g1hc_count_t rem;
  } g1hc_timer_s;

  // settle delay in clock cycles for a field value
  function automatic g1hc_count_t settle_cycles(input logic [2:0] sel);
    settle_cycles = 7'(sel * `G1HC_STEP_CYC);
  endfunction : settle_cycles

endpackage : g1hc_pkg

// ### g1hc_settle_if.sv
`timescale 1ns/1ps
interface g1hc_settle_if;
  logic start;
  g1hc_pkg::g1hc_count_t count;
  logic idle;
  modport ctrl (output start, output count, input idle);
  modport timer (input start, input count, output idle);
endinterface : g1hc_settle_if

// ### g1hc_settle_timer.sv
`timescale 1ns/1ps
module g1hc_settle_timer (
  input wire logic sys_clk, // board clock
  input wire logic rst, // async reset, active high
  g1hc_settle_if.timer tmr // start and count in, idle out
);

  g1hc_pkg::g1hc_timer_s q;
  g1hc_pkg::g1hc_timer_s d;

  // ----------------------------------------
  // down counter, reloaded on start
  // ----------------------------------------
  always_comb begin
    d = q;
    if (tmr.start) begin
      d.rem = tmr.count;
    end else if (q.rem != 7'h00) begin
      d.rem = q.rem - 7'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tmr.idle = (q.rem == 7'h00);

endmodule : g1hc_settle_timer

// ### g1hc_req_source.sv
`timescale 1ns/1ps
module g1hc_req_source (
  input wire logic sys_clk, // board clock
  input wire logic rst, // async reset, active high
  input wire logic want, // raise a request
  input wire logic activeLow, // request polarity
  input wire logic [2:0] lag, // cycles before data is taken
  input wire logic dataReady, // data ready from the block
  output logic reqPin, // request pin
  output logic taken // data consumed pulse
);
  logic [2:0] cnt_q;
  logic seen_q;
  assign reqPin = want ^ activeLow;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'h0;
      seen_q <= 1'b0;
      taken <= 1'b0;
    end else begin
      taken <= 1'b0;
      if (!want) begin
        cnt_q <= 3'h0;
        seen_q <= 1'b0;
      end else if (dataReady && !seen_q) begin
        if (cnt_q == lag) begin
          taken <= 1'b1;
          seen_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end
endmodule : g1hc_req_source

// ### g1hc_group1_handshake_config_bench.sv
`timescale 1ns/1ps
`include "g1hc_regs.svh"
module g1hc_group1_handshake_config_bench;
  logic sys_clk = 1'b0;
  logic rst;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, req, taken, dma, irqReq, irq, enA, enB, rdy, busy;
  logic [31:0] prdata;
  logic want = 1'b0;
  logic activeLow = 1'b0;
  logic [2:0] lag = 3'h0;
  logic [32:0] expQ[$];
  logic [32:0] e;
  logic [31:0] r;
  logic [15:0] cfg;
  int nMismatch = 0;
  int checked = 0;
  int n;

  always #4 sys_clk = ~sys_clk;

  g1hc_group1_handshake_config uut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .grp1RequestIn(req), .grp1DataTaken(taken),
    .grp1DmaRequest(dma), .grp1IrqRequest(irqReq), .irq(irq), .portAHandshakeEnable(enA),
    .portBHandshakeEnable(enB), .grp1DataReadyFlag(rdy), .grp1SettleBusy(busy));

  g1hc_req_source src (.sys_clk(sys_clk), .rst(rst), .want(want), .activeLow(activeLow),
    .lag(lag), .dataReady(rdy), .reqPin(req), .taken(taken));

  // ----
  // tasks
  // ----
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] exp);
    @(posedge sys_clk);
    if (!wr) expQ.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic waitFor(input logic useRdy, input logic v, input int lim);
    n = 0;
    while ((useRdy ? rdy : busy) !== v && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : waitFor

  task automatic end_of_test();
    $display("checked=%0d mismatches=%0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // read results are compared in order of issue
  always @(posedge sys_clk) begin
    if (psel && penable && !pwrite && pready) begin
      e = expQ.pop_front();
      chk({pslverr, prdata}, e);
    end
  end

  initial begin
    #200000;
    nMismatch++;
    end_of_test();
  end

  // ----
  // tests
  // ----
  initial begin
    rst <= 1'b1;
    void'($urandom(54));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({enA, enB, dma, irqReq, irq, rdy}, 33'h0);
    apb(1'b0, 8'h0c, 32'h0, 33'h4);
    apb(1'b0, 8'h00, 32'h0, 33'h0);
    apb(1'b0, 8'h10, 32'h0, 33'h100000000);
    $display("test reset done");
    for (int s = 0; s < 8; s++) begin
      r = $urandom;
      cfg = {r[0], r[1], 3'(s), r[2], ~r[2] | r[5], 1'b0, r[3], s[0], 6'h0};
      apb(1'b1, 8'h00, {25'h0, cfg[6], 6'h0}, 33'h0);
      activeLow <= cfg[6];
      apb(1'b1, 8'h08, {30'h0, r[5], r[5]}, 33'h0);
      apb(1'b0, 8'h08, 32'h0, {31'h0, r[5], r[5]});
      apb(1'b1, 8'h00, {16'h0, cfg}, 33'h0);
      lag <= r[8:6];
      want <= 1'b1;
      @(negedge sys_clk);
      chk({enA, enB}, {cfg[9], cfg[10]});
      waitFor(1'b0, 1'b1, 20);
      waitFor(1'b1, 1'b1, 1000);
      chk(33'(n), 33'(s * `G1HC_STEP_CYC + 1));
      chk({dma, irqReq, irq}, {cfg[15], cfg[14], r[5]});
      waitFor(1'b1, 1'b0, 20);
      chk({dma, irqReq, rdy}, 33'h0);
      @(posedge sys_clk);
      want <= 1'b0;
      apb(1'b0, 8'h04, 32'h0, 33'h3);
      @(negedge sys_clk);
      chk(irq, 1'b0);
      $display("test settle %0d done", s);
    end
    apb(1'b1, 8'h00, 32'h0, 33'h0);
    activeLow <= 1'b0;
    apb(1'b1, 8'h00, 32'h3e00, 33'h0);
    want <= 1'b1;
    repeat (10) @(negedge sys_clk);
    chk(busy, 1'b1);
    apb(1'b1, 8'h00, 32'h3f00, 33'h0);
    repeat (100) @(negedge sys_clk);
    chk({busy, rdy, enA, enB}, 33'h3);
    @(posedge sys_clk);
    want <= 1'b0;
    apb(1'b1, 8'h00, 32'h0, 33'h0);
    apb(1'b1, 8'h00, 32'h0600, 33'h0);
    want <= 1'b1;
    waitFor(1'b1, 1'b1, 20);
    chk(rdy, 1'b1);
    @(posedge sys_clk);
    want <= 1'b0;
    repeat (5) @(posedge sys_clk);
    $display("test local reset done");
    end_of_test();
  end
endmodule : g1hc_group1_handshake_config_bench
